// ### design/ams_defs.vh
// Constants for the asynchronous memory strobe sequencer: offsets, fields, resets, timing.
`ifndef AMS_DEFS_VH
`define AMS_DEFS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define AMS_REG_TIMING 8'h00
`define AMS_REG_WAIT_CFG 8'h04
`define AMS_REG_ACCESS_ADDR 8'h08
`define AMS_REG_WRITE_DATA 8'h0C
`define AMS_REG_COMMAND 8'h10
`define AMS_REG_STATUS 8'h14
`define AMS_REG_READ_DATA 8'h18
`define AMS_REG_INT_STATUS 8'h1C
`define AMS_REG_INT_MASK 8'h20

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define AMS_F_WRITE_SETUP 3:0
`define AMS_F_WRITE_STROBE 9:4
`define AMS_F_WRITE_HOLD 13:10
`define AMS_F_READ_SETUP 17:14
`define AMS_F_READ_STROBE 23:18
`define AMS_F_READ_HOLD 27:24
`define AMS_F_TURNAROUND 31:28
`define AMS_F_MAX_WAIT 7:0
`define AMS_B_EXT_WAIT_EN 8
`define AMS_F_ADDR 20:0
`define AMS_F_BANK 22:21
`define AMS_F_CS 25:24
`define AMS_B_CMD_READ 0
`define AMS_B_CMD_WRITE 1
`define AMS_B_EV_DONE 0
`define AMS_B_EV_TIMEOUT 1

// ----------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------
`define AMS_TIMING_RST 32'h11104441
`define AMS_WAIT_CFG_RST 32'h00000080
`define AMS_WAIT_CFG_MASK 32'h000001FF
`define AMS_ADDR_MASK 32'h03FFFFFF
`define AMS_DATA_MASK 32'h0000FFFF

// ----------------------------------------------------------------
// Timing counts in system clock cycles
// ----------------------------------------------------------------
`define AMS_WAIT_UNIT_CYC 5'h10
`define AMS_RELEASE_CYC 3'h4
`define AMS_SYNC_STAGES 3'h2

`endif

// ### design/ams_sequencer.v
// Asynchronous memory strobe sequencer with an AXI4-Lite register slave.
//
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
// Notes on behaviour
// - Phase lengths counted in whole system clock cycles
// - Phase counts and the wait limit are software registers
// - Turnaround gap of programmed cycles after each access
// - Read is setup plus strobe plus hold cycles
// - Extended wait adds sixteen cycles per wait unit
// - Read strobe low strobe count plus wait units
// - Bank and address valid setup before, hold after
// - Address stays stable through read hold cycles
// - Read strobe rises four cycles after wait release
// - Write is setup plus strobe plus hold cycles
// - Write strobe low strobe count plus wait units
// - Address and bank valid around write strobe too
// - Write data valid setup cycles before strobe falls
// - Write data driven through write hold cycles
// - Write strobe rises four cycles after wait release
// - Wait bounded by maximum limit, then timeout ends
`include "ams_defs.vh"

module ams_sequencer (
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	output reg [3:0] chip_select_n,
	output reg [1:0] bank_select,
	output reg [20:0] mem_addr,
	output reg [15:0] mem_data_out,
	output reg mem_data_oe,
	input wire [15:0] mem_data_in,
	output reg read_strobe_n,
	output reg write_strobe_n,
	input wire mem_wait_in,
	output wire irq
);
	// ----------------------------------------------------------------
	// Sequencer states
	// ----------------------------------------------------------------
	localparam ST_IDLE = 3'b000;
	localparam ST_SETUP = 3'b001;
	localparam ST_STROBE = 3'b010;
	localparam ST_EXTEND = 3'b011;
	localparam ST_HOLD = 3'b100;
	localparam ST_TURN = 3'b101;
	localparam RESP_OKAY = 2'b00;
	localparam RESP_SLVERR = 2'b10;
	// ----------------------------------------------------------------
	// Register storage
	// ----------------------------------------------------------------
	reg [31:0] timing, wait_cfg, access_addr, write_data;
	reg [15:0] read_data;
	reg [1:0] int_status, int_mask;
	reg cmd_read, cmd_write;
	reg aw_full, w_full;
	reg [7:0] aw_addr;
	reg [31:0] w_data;
	reg [3:0] w_strb;
	reg [2:0] state, next_state;
	reg [5:0] cnt, next_cnt;
	reg [3:0] sub_cnt, next_sub;
	reg [8:0] external_wait_count, next_ext;
	reg [1:0] rel_cnt, next_rel;
	reg timed_out, next_timed_out, cur_write, done_pulse, timeout_pulse;
	reg wait_s1, wait_s2;
	reg [15:0] data_s1, data_s2;
	wire extended_wait_enable = wait_cfg[`AMS_B_EXT_WAIT_EN];
	wire [7:0] max_wait_limit = wait_cfg[`AMS_F_MAX_WAIT];
	wire start = (state == ST_IDLE) && (cmd_read || cmd_write);
	wire next_write = start ? !cmd_read : cur_write;
	wire busy = (state != ST_IDLE);
	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------
	function addr_known;
		input [7:0] a;
		begin
			case (a)
			`AMS_REG_TIMING, `AMS_REG_WAIT_CFG, `AMS_REG_ACCESS_ADDR,
			`AMS_REG_WRITE_DATA, `AMS_REG_COMMAND, `AMS_REG_STATUS,
			`AMS_REG_READ_DATA, `AMS_REG_INT_STATUS, `AMS_REG_INT_MASK: addr_known = 1'b1;
			default: addr_known = 1'b0;
			endcase
		end
	endfunction
	function [31:0] apply_strb;
		input [31:0] old_val;
		input [31:0] new_val;
		input [3:0] strb;
		integer i;
		begin
			apply_strb = old_val;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i])
					apply_strb[i*8 +: 8] = new_val[i*8 +: 8];
			end
		end
	endfunction
	// A zero field behaves as one cycle so every phase is visible on the pins
	function [5:0] at_least_one;
		input [5:0] v;
		begin
			at_least_one = (v == 6'h00) ? 6'h01 : v;
		end
	endfunction
	function [5:0] phase_len;
		input [2:0] st;
		input wr;
		begin
			case (st)
			ST_SETUP: phase_len = at_least_one(wr ? {2'h0, timing[`AMS_F_WRITE_SETUP]}
				: {2'h0, timing[`AMS_F_READ_SETUP]});
			ST_STROBE: phase_len = at_least_one(wr ? timing[`AMS_F_WRITE_STROBE]
				: timing[`AMS_F_READ_STROBE]);
			ST_HOLD: phase_len = at_least_one(wr ? {2'h0, timing[`AMS_F_WRITE_HOLD]}
				: {2'h0, timing[`AMS_F_READ_HOLD]});
			ST_TURN: phase_len = at_least_one({2'h0, timing[`AMS_F_TURNAROUND]});
			default: phase_len = 6'h01;
			endcase
		end
	endfunction
	function is_active;
		input [2:0] st;
		begin
			is_active = (st == ST_SETUP) || (st == ST_STROBE) || (st == ST_EXTEND)
				|| (st == ST_HOLD);
		end
	endfunction
	function is_strobe;
		input [2:0] st;
		begin
			is_strobe = (st == ST_STROBE) || (st == ST_EXTEND);
		end
	endfunction
	wire phase_end = (cnt == phase_len(state, cur_write) - 6'h01);
	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	// Read data is taken from the second stage, so a strobe shorter than three
	// cycles returns data sampled before the memory had driven it.
	always @(posedge aclk) begin
		if (!aresetn) begin
			wait_s1 <= 1'b0;
			wait_s2 <= 1'b0;
			data_s1 <= 16'h0000;
			data_s2 <= 16'h0000;
		end else begin
			wait_s1 <= mem_wait_in;
			wait_s2 <= wait_s1;
			data_s1 <= mem_data_in;
			data_s2 <= data_s1;
		end
	end
	// ----------------------------------------------------------------
	// Phase sequencing
	// ----------------------------------------------------------------
	always @* begin
		next_state = state;
		next_cnt = cnt + 6'h01;
		next_sub = sub_cnt;
		next_ext = external_wait_count;
		next_rel = rel_cnt;
		next_timed_out = timed_out;
		done_pulse = 1'b0;
		timeout_pulse = 1'b0;
		case (state)
		ST_IDLE: begin
			next_cnt = 6'h00;
			if (start) begin
				next_state = ST_SETUP;
				next_ext = 9'h000;
				next_timed_out = 1'b0;
			end
		end
		ST_SETUP: begin
			if (phase_end) begin
				next_state = ST_STROBE;
				next_cnt = 6'h00;
			end
		end
		ST_STROBE: begin
			if (phase_end) begin
				next_cnt = 6'h00;
				if (extended_wait_enable && wait_s2) begin
					next_state = ST_EXTEND;
					next_sub = 4'h0;
					next_rel = 2'h0;
				end else begin
					next_state = ST_HOLD;
				end
			end
		end
		ST_EXTEND: begin
			next_cnt = 6'h00;
			next_sub = sub_cnt + 4'h1;
			if ({1'b0, sub_cnt} == `AMS_WAIT_UNIT_CYC - 5'h01)
				next_ext = external_wait_count + 9'h001;
			if (external_wait_count > {1'b0, max_wait_limit}) begin
				next_state = ST_HOLD;
				next_timed_out = 1'b1;
				timeout_pulse = 1'b1;
			end else if (!wait_s2) begin
				next_rel = rel_cnt + 2'h1;
				if ({1'b0, rel_cnt} == `AMS_RELEASE_CYC - `AMS_SYNC_STAGES - 3'h1)
					next_state = ST_HOLD;
			end else begin
				next_rel = 2'h0;
			end
		end
		ST_HOLD: begin
			if (phase_end) begin
				next_state = ST_TURN;
				next_cnt = 6'h00;
				done_pulse = 1'b1;
			end
		end
		ST_TURN: begin
			if (phase_end) begin
				next_state = ST_IDLE;
				next_cnt = 6'h00;
			end
		end
		default: begin
			next_state = ST_IDLE;
			next_cnt = 6'h00;
		end
		endcase
	end
	always @(posedge aclk) begin
		if (!aresetn) begin
			state <= ST_IDLE;
			cnt <= 6'h00;
			sub_cnt <= 4'h0;
			external_wait_count <= 9'h000;
			rel_cnt <= 2'h0;
			timed_out <= 1'b0;
			cur_write <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			sub_cnt <= next_sub;
			external_wait_count <= next_ext;
			rel_cnt <= next_rel;
			timed_out <= next_timed_out;
			cur_write <= next_write;
		end
	end
	// ----------------------------------------------------------------
	// Memory pins
	// ----------------------------------------------------------------
	// Pins are registered from the next state so strobes never glitch.
	always @(posedge aclk) begin
		if (!aresetn) begin
			chip_select_n <= 4'hF;
			bank_select <= 2'h0;
			mem_addr <= 21'h000000;
			mem_data_out <= 16'h0000;
			mem_data_oe <= 1'b0;
			read_strobe_n <= 1'b1;
			write_strobe_n <= 1'b1;
			read_data <= 16'h0000;
		end else begin
			if (start) begin
				mem_addr <= access_addr[`AMS_F_ADDR];
				bank_select <= access_addr[`AMS_F_BANK];
				mem_data_out <= write_data[15:0];
			end
			if (!is_active(next_state))
				chip_select_n <= 4'hF;
			else if (start)
				chip_select_n <= ~(4'h1 << access_addr[`AMS_F_CS]);
			mem_data_oe <= is_active(next_state) && next_write;
			read_strobe_n <= !(is_strobe(next_state) && !next_write);
			write_strobe_n <= !(is_strobe(next_state) && next_write);
			if (is_strobe(state) && (next_state == ST_HOLD) && !cur_write)
				read_data <= data_s2;
		end
	end
	// ----------------------------------------------------------------
	// AXI4-Lite write channel
	// ----------------------------------------------------------------
	assign s_axi_awready = !aw_full && !s_axi_bvalid;
	assign s_axi_wready = !w_full && !s_axi_bvalid;
	wire do_write = aw_full && w_full && !s_axi_bvalid;
	wire [1:0] ev_set = {timeout_pulse, done_pulse};
	wire [1:0] ev_clr = (do_write && (aw_addr == `AMS_REG_INT_STATUS) && w_strb[0]) ?
		w_data[1:0] : 2'h0;
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			timing <= `AMS_TIMING_RST;
			wait_cfg <= `AMS_WAIT_CFG_RST;
			access_addr <= 32'h00000000;
			write_data <= 32'h00000000;
			int_mask <= 2'h0;
			int_status <= 2'h0;
			cmd_read <= 1'b0;
			cmd_write <= 1'b0;
		end else begin
			cmd_read <= 1'b0;
			cmd_write <= 1'b0;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			// Set wins over a clear arriving in the same cycle
			int_status <= (int_status & ~ev_clr) | ev_set;
			if (do_write) begin
				aw_full <= 1'b0;
				w_full <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= addr_known(aw_addr) ? RESP_OKAY : RESP_SLVERR;
				case (aw_addr)
				`AMS_REG_TIMING: timing <= apply_strb(timing, w_data, w_strb);
				`AMS_REG_WAIT_CFG: wait_cfg <= apply_strb(wait_cfg, w_data, w_strb)
					& `AMS_WAIT_CFG_MASK;
				`AMS_REG_ACCESS_ADDR: access_addr <= apply_strb(access_addr, w_data, w_strb)
					& `AMS_ADDR_MASK;
				`AMS_REG_WRITE_DATA: write_data <= apply_strb(write_data, w_data, w_strb)
					& `AMS_DATA_MASK;
				`AMS_REG_INT_MASK: int_mask <= w_strb[0] ? w_data[1:0] : int_mask;
				`AMS_REG_COMMAND: begin
					// Commands while busy are dropped; software polls the busy bit
					cmd_read <= w_strb[0] && w_data[`AMS_B_CMD_READ] && !busy;
					cmd_write <= w_strb[0] && w_data[`AMS_B_CMD_WRITE] && !busy;
				end
				default: ;
				endcase
			end
		end
	end
	// ----------------------------------------------------------------
	// AXI4-Lite read channel
	// ----------------------------------------------------------------
	assign s_axi_arready = !s_axi_rvalid;
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= addr_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
				case (s_axi_araddr)
				`AMS_REG_TIMING: s_axi_rdata <= timing;
				`AMS_REG_WAIT_CFG: s_axi_rdata <= wait_cfg;
				`AMS_REG_ACCESS_ADDR: s_axi_rdata <= access_addr;
				`AMS_REG_WRITE_DATA: s_axi_rdata <= write_data;
				`AMS_REG_STATUS: s_axi_rdata <= {15'h0000, external_wait_count,
					6'h00, timed_out, busy};
				`AMS_REG_READ_DATA: s_axi_rdata <= {16'h0000, read_data};
				`AMS_REG_INT_STATUS: s_axi_rdata <= {30'h00000000, int_status};
				`AMS_REG_INT_MASK: s_axi_rdata <= {30'h00000000, int_mask};
				default: s_axi_rdata <= 32'h00000000;
				endcase
			end
		end
	end
	assign irq = |(int_status & int_mask);
endmodule // ams_sequencer

// ### verification/ams_checker.sv
// Pin-timing assertions for the sequencer, bound to its top module.
`timescale 1ns/1ps
module ams_checker (
	input wire aclk,
	input wire aresetn,
	input wire [3:0] chip_select_n,
	input wire [1:0] bank_select,
	input wire [20:0] mem_addr,
	input wire [15:0] mem_data_out,
	input wire mem_data_oe,
	input wire read_strobe_n,
	input wire write_strobe_n,
	input wire mem_wait_in
);
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	wire sel = chip_select_n != 4'hF;
	wire idle_stb = read_strobe_n & write_strobe_n;
	a_rd_setup: assert property ($fell(read_strobe_n) |-> $past(sel) && sel)
		else $error("read strobe fell without setup");
	a_rd_addr_stable: assert property (!read_strobe_n |->
		$stable(mem_addr) && $stable(bank_select))
		else $error("address moved under read strobe");
	a_rd_hold_addr: assert property ($rose(read_strobe_n) |-> sel ##1 $stable(mem_addr))
		else $error("read hold cut short");
	a_wr_data_setup: assert property ($fell(write_strobe_n) |->
		$past(mem_data_oe) && $stable(mem_data_out))
		else $error("write data not set up");
	a_wr_data_hold: assert property ($rose(write_strobe_n) |->
		mem_data_oe ##1 $stable(mem_data_out))
		else $error("write data hold cut short");
	a_wr_addr_stable: assert property (!write_strobe_n |->
		sel && $stable(mem_addr) && $stable(bank_select))
		else $error("address moved under write strobe");
	a_turn_gap: assert property ($rose(&chip_select_n) |=> &chip_select_n)
		else $error("no turnaround gap");
	// Two synchroniser stages plus two counted cycles: the strobe rises four cycles after the pin
	a_wait_release: assert property ($fell(mem_wait_in) && !idle_stb |->
		!idle_stb[*4] ##1 idle_stb)
		else $error("strobe not released after wait");
	c_rd: cover property ($rose(read_strobe_n));
	c_wr: cover property ($rose(write_strobe_n));
	c_wait: cover property ($fell(mem_wait_in) && !idle_stb);
endmodule // ams_checker

bind ams_sequencer ams_checker u_chk (.aclk(aclk), .aresetn(aresetn),
	.chip_select_n(chip_select_n), .bank_select(bank_select), .mem_addr(mem_addr),
	.mem_data_out(mem_data_out),
	.mem_data_oe(mem_data_oe), .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
	.mem_wait_in(mem_wait_in));

// ### verification/ams_mem_model.sv
// Behavioural asynchronous memory with a commanded wait pulse.
`timescale 1ns/1ps
module ams_mem_model (
	input wire aclk,
	input wire [3:0] chip_select_n,
	input wire [1:0] bank_select,
	input wire [20:0] mem_addr,
	input wire [15:0] mem_data_out,
	input wire mem_data_oe,
	input wire read_strobe_n,
	input wire write_strobe_n,
	input wire [8:0] wait_len,
	output logic [15:0] mem_data_in,
	output logic mem_wait_in
);
	logic [15:0] mem [0:63];
	logic [15:0] last = 16'h0000;
	logic was_sel = 1'b0;
	int wcnt = 0;
	wire sel = chip_select_n != 4'hF;
	wire [5:0] idx = {bank_select, mem_addr[3:0]};
	// Released bus shows the inverse of the last word so a stale sample cannot match
	assign mem_data_in = (sel && !read_strobe_n) ? mem[idx] : ~last;
	initial mem_wait_in = 1'b0;
	always @(posedge write_strobe_n) begin
		if (sel && mem_data_oe)
			mem[idx] <= mem_data_out;
	end
	always @(posedge aclk) begin
		was_sel <= sel;
		if (sel && !read_strobe_n)
			last <= mem[idx];
		if (wcnt > 0) begin
			wcnt <= wcnt - 1;
			mem_wait_in <= wcnt > 1;
		end else if (sel && !was_sel && wait_len > 9'h001) begin
			mem_wait_in <= 1'b1;
			wcnt <= wait_len;
		end
	end
endmodule // ams_mem_model

// ### verification/async_memory_strobe_sequencer_tb.sv
// Self-checking bench: register master, pin monitor and memory partner.
`timescale 1ns/1ps
`include "ams_defs.vh"
module async_memory_strobe_sequencer_tb;
	typedef struct {logic [31:0] m; logic [31:0] d; logic [1:0] r;} ams_note_t;
	typedef struct {logic [3:0] c; int n; int s; bit ge;} ams_pin_t;
	logic aclk, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, got;
	logic [15:0] lf = 16'h005F;
	logic [8:0] wl = 9'h000;
	wire awready, wready, bvalid, arready, rvalid, oe, rs_n, ws_n, wt, irq;
	wire [1:0] bresp, rresp, bank;
	wire [31:0] rdata;
	wire [3:0] cs;
	wire [20:0] addr;
	wire [15:0] din, dout;
	int errors = 0, n_checks = 0, cn = 0, sn = 0;
	ams_note_t rq[$];
	logic [1:0] bq[$];
	ams_pin_t pq[$];
	ams_sequencer uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .chip_select_n(cs), .bank_select(bank), .mem_addr(addr),
		.mem_data_out(dout), .mem_data_oe(oe), .mem_data_in(din), .read_strobe_n(rs_n),
		.write_strobe_n(ws_n), .mem_wait_in(wt), .irq(irq));
	ams_mem_model u_mem (.aclk(aclk), .chip_select_n(cs), .bank_select(bank), .mem_addr(addr),
		.mem_data_out(dout), .mem_data_oe(oe), .read_strobe_n(rs_n), .write_strobe_n(ws_n),
		.wait_len(wl), .mem_data_in(din), .mem_wait_in(wt));
	function automatic logic [15:0] nx(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	task automatic finish_test();
		if (errors == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [35:0] g, input logic [35:0] e);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		bit ta, tw;
		bq.push_back(r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		ta = 0;
		tw = 0;
		while (!(ta && tw)) begin
			@(posedge aclk);
			if (awready === 1'b1 && !ta)
				awvalid <= 1'b0;
			if (wready === 1'b1 && !tw)
				wvalid <= 1'b0;
			ta = ta | (awready === 1'b1);
			tw = tw | (wready === 1'b1);
		end
		while (bvalid !== 1'b1)
			@(posedge aclk);
		bready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
		input logic [1:0] r);
		rq.push_back('{m, e, r});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
			@(posedge aclk);
		while (arready !== 1'b1);
		arvalid <= 1'b0;
		do
			@(posedge aclk);
		while (rvalid !== 1'b1);
		got = rdata;
		rready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic idle();
		int k;
		k = 0;
		do begin
			rd(`AMS_REG_STATUS, 32'h0, 32'h0, 2'b00);
			k++;
		end while (got[0] !== 1'b0 && k < 500);
		chk(36'(got[0]), 36'h0);
	endtask
	// Bank follows the chip-select index so one argument moves both fields
	task automatic acc(input bit w, input logic [1:0] c, input logic [3:0] a, input int n,
		input int s, input bit ge);
		pq.push_back('{~(4'h1 << c), n, s, ge});
		wr(`AMS_REG_ACCESS_ADDR, {6'h00, c, 1'b0, c, 17'h00000, a}, 2'b00);
		wr(`AMS_REG_COMMAND, {30'h0, w, ~w}, 2'b00);
		idle();
	endtask
	always @(posedge aclk) begin
		ams_note_t q;
		if (rvalid === 1'b1 && rready) begin
			if (rq.size() == 0)
				chk(36'h1, 36'h0);
			else begin
				q = rq.pop_front();
				if (q.m != 32'h0)
					chk({2'b00, rresp, rdata & q.m}, {2'b00, q.r, q.d});
			end
		end
		if (bvalid === 1'b1 && bready)
			chk(36'(bresp), 36'(bq.pop_front()));
	end
	// With ge set a length is a lower bound: wait stretching is not cycle exact
	always @(posedge aclk) begin
		ams_pin_t p;
		if (!aresetn) begin
			cn = 0;
			sn = 0;
		end else if (cs !== 4'hF) begin
			if (cn == 0 && pq.size() != 0)
				chk(36'(cs), 36'(pq[0].c));
			cn++;
			if (!(rs_n && ws_n))
				sn++;
		end else if (cn != 0) begin
			if (pq.size() == 0)
				chk(36'h1, 36'h0);
			else begin
				p = pq.pop_front();
				chk(36'(p.ge && cn > p.n ? p.n : cn), 36'(p.n));
				chk(36'(p.ge && sn > p.s ? p.s : sn), 36'(p.s));
			end
			cn = 0;
			sn = 0;
		end
	end
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	initial begin
		#200000;
		errors++;
		finish_test();
	end
	initial begin
		int i;
		logic [3:0] s, h, ta;
		logic [5:0] t;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(`AMS_REG_TIMING, 32'hFFFFFFFF, `AMS_TIMING_RST, 2'b00);
		rd(`AMS_REG_WAIT_CFG, 32'hFFFFFFFF, `AMS_WAIT_CFG_RST, 2'b00);
		rd(8'h24, 32'hFFFFFFFF, 32'h0, 2'b10);
		wr(8'h24, 32'h1, 2'b10);
		for (i = 0; i < 4; i++) begin
			lf = nx(lf);
			s = 4'h1 + lf[1:0];
			t = 6'h03 + lf[4:2];
			h = 4'h1 + lf[6:5];
			ta = 4'h1 + lf[8:7];
			wr(`AMS_REG_TIMING, {ta, h, t, s, h, t, s}, 2'b00);
			wr(`AMS_REG_WRITE_DATA, {16'h0000, lf}, 2'b00);
			acc(1'b1, i[1:0], lf[15:12], s + t + h, t, 1'b0);
			acc(1'b0, i[1:0], lf[15:12], s + t + h, t, 1'b0);
			rd(`AMS_REG_READ_DATA, 32'h0000FFFF, {16'h0000, lf}, 2'b00);
		end
		chk(36'(irq), 36'h0);
		rd(`AMS_REG_INT_STATUS, 32'h1, 32'h1, 2'b00);
		wr(`AMS_REG_INT_MASK, 32'h3, 2'b00);
		chk(36'(irq), 36'h1);
		wr(`AMS_REG_INT_STATUS, 32'h1, 2'b00);
		chk(36'(irq), 36'h0);
		wr(`AMS_REG_TIMING, `AMS_TIMING_RST, 2'b00);
		pq.push_back('{4'hE, 6, 4, 1'b0});
		wr(`AMS_REG_ACCESS_ADDR, 32'h0, 2'b00);
		wr(`AMS_REG_COMMAND, 32'h1, 2'b00);
		wr(`AMS_REG_COMMAND, 32'h2, 2'b00);
		idle();
		wr(`AMS_REG_WAIT_CFG, 32'h00000108, 2'b00);
		wl <= 9'h028;
		wr(`AMS_REG_WRITE_DATA, 32'h0000A55A, 2'b00);
		acc(1'b1, 2'h3, 4'h9, 44, 40, 1'b1);
		acc(1'b0, 2'h3, 4'h9, 44, 40, 1'b1);
		rd(`AMS_REG_READ_DATA, 32'h0000FFFF, 32'h0000A55A, 2'b00);
		wr(`AMS_REG_WAIT_CFG, 32'h00000101, 2'b00);
		wl <= 9'h0C8;
		acc(1'b0, 2'h1, 4'h2, 34, 32, 1'b1);
		rd(`AMS_REG_INT_STATUS, 32'h2, 32'h2, 2'b00);
		rd(`AMS_REG_STATUS, 32'h2, 32'h2, 2'b00);
		chk(36'(pq.size() + rq.size() + bq.size()), 36'h0);
		finish_test();
	end
endmodule // async_memory_strobe_sequencer_tb
